// ===== hdl/dsc_pkg.sv
// Package of offsets, field layouts and reset values for the clock gating block.
package dsc_pkg;

    // Register offsets.
    localparam logic [11:0] RUN_GATE_OFS   = 12'h104;
    localparam logic [11:0] SLEEP_GATE_OFS = 12'h114;
    localparam logic [11:0] DEEP_GATE_OFS  = 12'h124;
    localparam logic [11:0] RUN_CFG_OFS    = 12'h060;
    localparam logic [11:0] IRQ_STAT_OFS   = 12'h130;
    localparam logic [11:0] IRQ_EN_OFS     = 12'h134;
    localparam logic [11:0] IRQ_CLR_OFS    = 12'h138;

    // Gating bit positions.
    localparam int COMP_TWO_POS   = 26;
    localparam int COMP_ONE_POS   = 25;
    localparam int COMP_ZERO_POS  = 24;
    localparam int TIMER_TWO_POS  = 18;
    localparam int TIMER_ONE_POS  = 17;
    localparam int TIMER_ZERO_POS = 16;
    localparam int I2C_POS        = 12;
    localparam int SSI_POS        = 4;
    localparam int UART_ONE_POS   = 1;
    localparam int UART_ZERO_POS  = 0;

    // Number of gated units.
    localparam int NUM_UNITS = 10;

    // Writable bits of a gating register; all others read as zero.
    localparam logic [31:0] GATE_MASK  = 32'h0707_1013;
    localparam logic [31:0] GATE_RESET = 32'h0000_0000;

    // Automatic gating select bit in the run configuration register.
    localparam int          AUTO_GATE_POS = 27;
    localparam logic [31:0] CFG_MASK      = 32'h0800_0000;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0000;

    // Power mode codes on the mode input.
    localparam logic [1:0] MODE_RUN   = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_DEEP  = 2'h2;

    // One-hot mode states.
    typedef enum logic [2:0] {
        DSC_RUN   = 3'h1,
        DSC_SLEEP = 3'h2,
        DSC_DEEP  = 3'h4
    } dsc_mode_e;

    // Extracts the per-unit enables from a gating register word.
    function automatic logic [NUM_UNITS-1:0] dsc_units(input logic [31:0] w);
        dsc_units = {w[COMP_TWO_POS], w[COMP_ONE_POS], w[COMP_ZERO_POS],
                     w[TIMER_TWO_POS], w[TIMER_ONE_POS], w[TIMER_ZERO_POS],
                     w[I2C_POS], w[SSI_POS], w[UART_ONE_POS],
                     w[UART_ZERO_POS]};
    endfunction : dsc_units

endpackage : dsc_pkg

// ===== hdl/dsc_gate_reg.sv
// Masked software-writable gating register.
`timescale 1ns/1ps
`default_nettype none
module dsc_gate_reg
    import dsc_pkg::*;
#(
    parameter logic [31:0] MASK  = GATE_MASK,
    parameter logic [31:0] RESET = GATE_RESET
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Write port.
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    // Stored value.
    output logic      [31:0] value
);

    typedef struct packed {
        logic [31:0] word;
    } dsc_greg_s;

    dsc_greg_s st;
    dsc_greg_s next_st;

    always_comb begin
        next_st = st;
        // Reserved bits stay zero.
        if (wr_en) begin
            next_st.word = wr_data & MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st.word <= RESET;
        end else begin
            st <= next_st;
        end
    end

    assign value = st.word;

endmodule : dsc_gate_reg
`default_nettype wire

// ===== hdl/dsc_mode_sel.sv
// Power mode tracker that selects the active gating set.
`timescale 1ns/1ps
`default_nettype none
module dsc_mode_sel
    import dsc_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Mode and selection inputs.
    input  wire logic [1:0]  pwr_mode,
    input  wire logic        auto_gating_select,
    input  wire logic [31:0] run_set,
    input  wire logic [31:0] sleep_set,
    input  wire logic [31:0] deep_set,
    // Selected set and mode.
    output logic      [31:0] active_set,
    output dsc_mode_e        mode
);

    typedef struct packed {
        dsc_mode_e mode;
    } dsc_msel_s;

    dsc_msel_s st;
    dsc_msel_s next_st;

    always_comb begin
        next_st = st;
        unique case (pwr_mode)
            MODE_SLEEP: next_st.mode = DSC_SLEEP;
            MODE_DEEP:  next_st.mode = DSC_DEEP;
            default:    next_st.mode = DSC_RUN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st.mode <= DSC_RUN;
        end else begin
            st <= next_st;
        end
    end

    assign mode = st.mode;

    always_comb begin
        active_set = run_set;
        if (auto_gating_select) begin
            unique case (st.mode)
                DSC_SLEEP: active_set = sleep_set;
                DSC_DEEP:  active_set = deep_set;
                default:   active_set = run_set;
            endcase
        end
    end

endmodule : dsc_mode_sel
`default_nettype wire

// ===== hdl/dsc_clock_gate.sv
// Top of the peripheral clock gating block with register port and faults.
`timescale 1ns/1ps
`default_nettype none
module dsc_clock_gate
    import dsc_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // Register port.
    input  wire logic [11:0]          reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // Power mode.
    input  wire logic [1:0]           pwr_mode,
    // Peripheral side.
    input  wire logic [NUM_UNITS-1:0] periph_access,
    output logic      [NUM_UNITS-1:0] unit_clk_en,
    output logic                      bus_fault,
    // Interrupt.
    output logic                      irq
);

    typedef struct packed {
        logic [31:0]          rdata;
        logic [NUM_UNITS-1:0] clk_en;
        logic                 fault;
        logic [NUM_UNITS-1:0] irq_stat;
        logic [NUM_UNITS-1:0] irq_en;
        logic                 irq;
    } dsc_top_s;

    dsc_top_s st;
    dsc_top_s next_st;

    logic [31:0] run_set;
    logic [31:0] sleep_set;
    logic [31:0] deep_set;
    logic [31:0] run_cfg;
    logic [31:0] active_set;
    logic [NUM_UNITS-1:0] fault_vec;

    // Write strobe decode for one register offset.
    function automatic logic dsc_wr_hit(input logic        wr,
                                        input logic [11:0] addr,
                                        input logic [11:0] ofs);
        dsc_wr_hit = wr && (addr == ofs);
    endfunction : dsc_wr_hit

    dsc_gate_reg #(.MASK(GATE_MASK), .RESET(GATE_RESET)) u_run (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (dsc_wr_hit(reg_wr, reg_addr, RUN_GATE_OFS)),
        .wr_data (reg_wdata),
        .value   (run_set)
    );

    dsc_gate_reg #(.MASK(GATE_MASK), .RESET(GATE_RESET)) u_sleep (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (dsc_wr_hit(reg_wr, reg_addr, SLEEP_GATE_OFS)),
        .wr_data (reg_wdata),
        .value   (sleep_set)
    );

    dsc_gate_reg #(.MASK(GATE_MASK), .RESET(GATE_RESET)) u_deep (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (dsc_wr_hit(reg_wr, reg_addr, DEEP_GATE_OFS)),
        .wr_data (reg_wdata),
        .value   (deep_set)
    );

    dsc_gate_reg #(.MASK(CFG_MASK), .RESET(CFG_RESET)) u_cfg (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (dsc_wr_hit(reg_wr, reg_addr, RUN_CFG_OFS)),
        .wr_data (reg_wdata),
        .value   (run_cfg)
    );

    dsc_mode_sel u_mode (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .pwr_mode           (pwr_mode),
        .auto_gating_select (run_cfg[AUTO_GATE_POS]),
        .run_set            (run_set),
        .sleep_set          (sleep_set),
        .deep_set           (deep_set),
        .active_set         (active_set),
        .mode               ()
    );

    assign fault_vec = periph_access & ~st.clk_en;

    always_comb begin
        next_st = st;
        next_st.clk_en = dsc_units(active_set);
        next_st.fault = |fault_vec;
        if (dsc_wr_hit(reg_wr, reg_addr, IRQ_EN_OFS)) begin
            next_st.irq_en = reg_wdata[NUM_UNITS-1:0];
        end
        // Set wins over a clear in the same cycle.
        if (dsc_wr_hit(reg_wr, reg_addr, IRQ_CLR_OFS)) begin
            next_st.irq_stat = st.irq_stat & ~reg_wdata[NUM_UNITS-1:0];
        end
        next_st.irq_stat = next_st.irq_stat | fault_vec;
        next_st.irq = |(next_st.irq_stat & next_st.irq_en);
        next_st.rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                RUN_GATE_OFS:   next_st.rdata = run_set;
                SLEEP_GATE_OFS: next_st.rdata = sleep_set;
                DEEP_GATE_OFS:  next_st.rdata = deep_set;
                RUN_CFG_OFS:    next_st.rdata = run_cfg;
                IRQ_STAT_OFS:   next_st.rdata[NUM_UNITS-1:0] = st.irq_stat;
                IRQ_EN_OFS:     next_st.rdata[NUM_UNITS-1:0] = st.irq_en;
                default:        next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata   = st.rdata;
    assign unit_clk_en = st.clk_en;
    assign bus_fault   = st.fault;
    assign irq         = st.irq;

endmodule : dsc_clock_gate
`default_nettype wire

// ===== tb/dsc_gate_properties.sv
// Port checker of the clock gating block.
`timescale 1ns/1ps
`default_nettype none
module dsc_gate_props
    import dsc_pkg::*;
(
    // Clock and register port.
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic [11:0]          reg_addr,
    input wire logic [31:0]          reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    // Mode, units and interrupt.
    input wire logic [1:0]           pwr_mode,
    input wire logic [NUM_UNITS-1:0] periph_access,
    input wire logic [NUM_UNITS-1:0] unit_clk_en,
    input wire logic                 bus_fault,
    input wire logic                 irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [NUM_UNITS-1:0] gated;
    assign gated = periph_access & ~unit_clk_en;
    fault_gated_a: assert property (|gated |=> bus_fault)
        else $error("No fault on gated access.");
    fault_clocked_a: assert property (!(|gated) |=> !bus_fault)
        else $error("Fault on clocked access.");
    reset_clear_a: assert property ($fell(rst) |->
        unit_clk_en == '0 && !irq) else $error("Outputs not reset.");
    gate_cause_a: assert property ($changed(unit_clk_en) |->
        $past(reg_wr) || $past(reg_wr, 2) ||
        $past(pwr_mode) != $past(pwr_mode, 3))
        else $error("Gating changed without cause.");
    rdata_idle_a: assert property (!$past(reg_rd) |->
        reg_rdata == '0) else $error("Read data without read.");
    deep_rsvd_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == DEEP_GATE_OFS |-> (reg_rdata & ~GATE_MASK) == '0)
        else $error("Reserved gating bits set.");
    cfg_rsvd_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == RUN_CFG_OFS |-> (reg_rdata & ~CFG_MASK) == '0)
        else $error("Reserved config bits set.");
    irq_cause_a: assert property ($rose(irq) |-> bus_fault ||
        $past(bus_fault) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("Interrupt without cause.");
    cover property (bus_fault);
    cover property ($rose(irq));
    cover property (&unit_clk_en);
endmodule : dsc_gate_props
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the clock gating block.
`timescale 1ns/1ps
`default_nettype none
module tb
    import dsc_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [1:0]  pwr_mode = 2'h0;
    logic [9:0]  periph_access = 10'h0;
    logic [31:0] reg_rdata;
    logic [9:0]  unit_clk_en;
    logic        bus_fault;
    logic        irq;
    int          fails = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          pos [10] = '{UART_ZERO_POS, UART_ONE_POS, SSI_POS, I2C_POS,
        TIMER_ZERO_POS, TIMER_ONE_POS, TIMER_TWO_POS, COMP_ZERO_POS,
        COMP_ONE_POS, COMP_TWO_POS};
    dsc_clock_gate u_dsc_clock_gate (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .pwr_mode      (pwr_mode),
        .periph_access (periph_access),
        .unit_clk_en   (unit_clk_en),
        .bus_fault     (bus_fault),
        .irq           (irq)
    );
    always #12.5 clk_sys = ~clk_sys;
    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk("rdata", reg_rdata, e);
    endtask : rd
    task automatic en(input logic [31:0] e);
        repeat (3) @(posedge clk_sys);
        #1 chk("clk_en", unit_clk_en, e);
    endtask : en
    task automatic md(input logic [1:0] m, input logic [31:0] e);
        @(posedge clk_sys);
        pwr_mode <= m;
        en(e);
    endtask : md
    task automatic hit(input logic [9:0] a, input logic f);
        @(posedge clk_sys);
        periph_access <= a;
        @(posedge clk_sys);
        periph_access <= 10'h0;
        #1 chk("fault", bus_fault, f);
    endtask : hit
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rd(DEEP_GATE_OFS, GATE_RESET);
        rd(RUN_GATE_OFS, 32'h0);
        rd(SLEEP_GATE_OFS, 32'h0);
        rd(RUN_CFG_OFS, CFG_RESET);
        chk("clk_en", unit_clk_en, 32'h0);
        hit(10'h010, 1'b1);
        $display("reset test done");
        for (int k = 0; k < NUM_UNITS; k++) begin
            wr(RUN_GATE_OFS, 32'h1 << pos[k]);
            en(32'h1 << k);
        end
        wr(RUN_GATE_OFS, 32'hffff_ffff);
        rd(RUN_GATE_OFS, GATE_MASK);
        en(32'h3ff);
        hit(10'h3ff, 1'b0);
        wr(DEEP_GATE_OFS, 32'hffff_ffff);
        rd(DEEP_GATE_OFS, GATE_MASK);
        wr(SLEEP_GATE_OFS, 32'h1 << UART_ZERO_POS);
        wr(RUN_GATE_OFS, 32'h0);
        md(MODE_DEEP, 32'h0);
        wr(RUN_CFG_OFS, 32'hffff_ffff);
        rd(RUN_CFG_OFS, CFG_MASK);
        en(32'h3ff);
        md(MODE_SLEEP, 32'h1);
        md(MODE_RUN, 32'h0);
        $display("gating test done");
        md(MODE_SLEEP, 32'h1);
        wr(IRQ_EN_OFS, 32'hffff_fc02);
        rd(IRQ_EN_OFS, 32'h2);
        hit(10'h003, 1'b1);
        hit(10'h001, 1'b0);
        rd(IRQ_STAT_OFS, 32'h012);
        chk("irq", irq, 1'b1);
        wr(IRQ_CLR_OFS, 32'h3ff);
        rd(IRQ_STAT_OFS, 32'h0);
        chk("irq", irq, 1'b0);
        hit(10'h200, 1'b1);
        rd(IRQ_STAT_OFS, 32'h200);
        chk("irq", irq, 1'b0);
        rd(IRQ_CLR_OFS, 32'h0);
        rd(12'h200, 32'h0);
        $display("fault test done");
        md(2'h3, 32'h0);
        wr(RUN_GATE_OFS, 32'hffff_ffff);
        wr(IRQ_EN_OFS, 32'h3ff);
        en(32'h3ff);
        chk("irq", irq, 1'b1);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(RUN_GATE_OFS, GATE_RESET);
        chk("irq", irq, 1'b0);
        chk("clk_en", unit_clk_en, 32'h0);
        rd(DEEP_GATE_OFS, GATE_RESET);
        rd(RUN_CFG_OFS, CFG_RESET);
        rd(IRQ_STAT_OFS, 32'h0);
        rd(IRQ_EN_OFS, 32'h0);
        $display("second reset test done");
        complete_run();
    end
endmodule : tb
bind dsc_clock_gate dsc_gate_props u_dsc_gate_props (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .pwr_mode      (pwr_mode),
    .periph_access (periph_access),
    .unit_clk_en   (unit_clk_en),
    .bus_fault     (bus_fault),
    .irq           (irq)
);
`default_nettype wire
